// ===== core/egpio_pkg.sv
// Package for the eight-bit port with analog-shared pins
package egpio_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam logic [11:0] EGPIO_OFF_LATCH = 12'h000;
	localparam logic [11:0] EGPIO_OFF_DIR = 12'h004;
	localparam logic [11:0] EGPIO_OFF_PULL = 12'h008;
	localparam logic [11:0] EGPIO_OFF_AIDL = 12'h00c;
	localparam logic [11:0] EGPIO_OFF_STBY = 12'h010;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] EGPIO_RST_LATCH = 8'h00;
	localparam logic [7:0] EGPIO_RST_DIR = 8'h00;
	localparam logic [7:0] EGPIO_RST_PULL = 8'h00;
	localparam logic [3:0] EGPIO_RST_AIDL = 4'h0;
	localparam logic EGPIO_RST_SPL = 1'b0;

	// ------------------------------------------------------------
	// Pin layout
	// ------------------------------------------------------------
	localparam logic [7:0] EGPIO_ANALOG_PINS = 8'h33;
	localparam logic [7:0] EGPIO_OPEN_DRAIN_PINS = 8'hc0;
	localparam logic [7:0] EGPIO_PULL_PINS = 8'h3f;
	localparam int EGPIO_IRQ6_PIN = 2;
	localparam int EGPIO_IRQ7_PIN = 3;
	localparam int EGPIO_STBY_SPL_BIT = 0;

	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe_b;
		logic [7:0] pull_en;
	} egpio_pad_t;

	typedef struct packed {
		logic [7:0] oe;
		logic [7:0] dat;
	} egpio_periph_t;

endpackage : egpio_pkg

// ===== core/egpio_port.sv
// Eight-bit port: latch, direction, pull-up, analog disable, standby isolation
`timescale 1ns/1ps
`default_nettype none
module egpio_port
	import egpio_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rmw_read_i,
	input wire egpio_periph_t periph_i,
	input wire logic standby_stop_watch_i,
	input wire logic [1:0] ext_irq_enable_i,
	input wire logic [7:0] pad_in_i,
	output egpio_pad_t pad_o,
	output logic ext_irq_input_six_o,
	output logic ext_irq_input_seven_o,
	output logic [3:0] analog_sel_o
);

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [7:0] port_output_latch_q;
	logic [7:0] port_direction_select_q;
	logic [7:0] port_pullup_enable_q;
	logic [3:0] analog_input_disable_low_q;
	logic standby_pin_state_select_q;
	logic [7:0] sync1_q;
	logic [7:0] sync2_q;
	logic [31:0] prdata_q;
	logic pready_q;
	logic pslverr_q;
	egpio_pad_t pad_q;
	egpio_pad_t pad_d;
	logic irq6_q;
	logic irq7_q;
	logic [3:0] analog_sel_q;

	logic acc_first;
	logic wr_en;
	logic rd_en;
	logic [4:0] reg_sel;
	logic sel_latch;
	logic sel_dir;
	logic sel_pull;
	logic sel_aidl;
	logic sel_stby;
	logic sel_none;
	logic lane0;
	logic [7:0] wr_byte;
	logic [7:0] port_read;
	logic [7:0] irq_keep;
	logic [7:0] drv_on;
	logic [7:0] drv_val;
	logic [7:0] pull_on;
	logic isolate;
	logic [7:0] in_enable;
	logic [7:0] pin_level;
	logic [7:0] periph_oe;

	// Expand the four analog-disable bits onto pins 0,1,4,5
	function automatic logic [7:0] egpio_aidl_expand(input logic [3:0] a);
		egpio_aidl_expand = {2'b11, a[3:2], 2'b11, a[1:0]};
	endfunction : egpio_aidl_expand

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// One-hot select, shared by write strobes, read mux and error flag
	function automatic logic [4:0] egpio_decode(input logic [11:0] a);
		egpio_decode = 5'b0_0000;
		if (a == EGPIO_OFF_LATCH) begin
			egpio_decode = 5'b0_0001;
		end else if (a == EGPIO_OFF_DIR) begin
			egpio_decode = 5'b0_0010;
		end else if (a == EGPIO_OFF_PULL) begin
			egpio_decode = 5'b0_0100;
		end else if (a == EGPIO_OFF_AIDL) begin
			egpio_decode = 5'b0_1000;
		end else if (a == EGPIO_OFF_STBY) begin
			egpio_decode = 5'b1_0000;
		end
	endfunction : egpio_decode

	// Data-register read per pin; RMW reads always see the latch
	function automatic logic [7:0] egpio_port_read(
		input logic rmw,
		input logic [7:0] latch,
		input logic [7:0] dir,
		input logic [7:0] poe,
		input logic [7:0] level
	);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (rmw) begin
				r[i] = latch[i];
			end else if (poe[i]) begin
				r[i] = level[i];
			end else if (dir[i]) begin
				r[i] = latch[i];
			end else begin
				r[i] = level[i];
			end
		end
		egpio_port_read = r;
	endfunction : egpio_port_read

	// ------------------------------------------------------------
	// APB slave, one wait state
	// ------------------------------------------------------------
	// Reads are prepared on the first access cycle so data stands with ready;
	// writes land only on the edge that completes the transfer
	assign acc_first = clk_en_i && psel_i && penable_i && !pready_q;
	assign rd_en = acc_first && !pwrite_i;
	assign wr_en = clk_en_i && psel_i && penable_i && pready_q && pwrite_i && lane0;
	assign lane0 = pstrb_i[0];
	assign wr_byte = pwdata_i[7:0];
	assign reg_sel = egpio_decode(paddr_i);
	assign sel_latch = reg_sel[0];
	assign sel_dir = reg_sel[1];
	assign sel_pull = reg_sel[2];
	assign sel_aidl = reg_sel[3];
	assign sel_stby = reg_sel[4];
	assign sel_none = ~|reg_sel;

	// Latch writes land whatever the direction
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port_output_latch_q <= EGPIO_RST_LATCH;
		end else if (wr_en && sel_latch) begin
			port_output_latch_q <= wr_byte;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port_direction_select_q <= EGPIO_RST_DIR;
		end else if (wr_en && sel_dir) begin
			port_direction_select_q <= wr_byte;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			port_pullup_enable_q <= EGPIO_RST_PULL;
		end else if (wr_en && sel_pull) begin
			port_pullup_enable_q <= wr_byte;
		end
	end

	// Field bits 2,3,6,7 map to pins 0,1,4,5
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			analog_input_disable_low_q <= EGPIO_RST_AIDL;
		end else if (wr_en && sel_aidl) begin
			analog_input_disable_low_q <= {wr_byte[7:6], wr_byte[3:2]};
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			standby_pin_state_select_q <= EGPIO_RST_SPL;
		end else if (wr_en && sel_stby) begin
			standby_pin_state_select_q <= wr_byte[EGPIO_STBY_SPL_BIT];
		end
	end

	// ------------------------------------------------------------
	// Input path
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
		end else if (clk_en_i) begin
			sync1_q <= pad_in_i;
			sync2_q <= sync1_q;
		end
	end

	assign isolate = standby_pin_state_select_q && standby_stop_watch_i;

	// ------------------------------------------------------------
	// Isolation
	// ------------------------------------------------------------
	// Interrupt pins stay open in isolation only while their interrupt is on
	always_comb begin
		irq_keep = 8'h00;
		irq_keep[EGPIO_IRQ6_PIN] = ext_irq_enable_i[0];
		irq_keep[EGPIO_IRQ7_PIN] = ext_irq_enable_i[1];
	end

	// Blocked inputs read low: analog pins and isolated pins
	always_comb begin
		in_enable = egpio_aidl_expand(analog_input_disable_low_q);
		if (isolate) begin
			in_enable = irq_keep;
		end
	end

	assign pin_level = sync2_q & in_enable;

	// Interrupt feed ignores direction and peripheral use
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq6_q <= 1'b0;
			irq7_q <= 1'b0;
		end else if (clk_en_i) begin
			irq6_q <= pin_level[EGPIO_IRQ6_PIN];
			irq7_q <= pin_level[EGPIO_IRQ7_PIN];
		end
	end

	// ------------------------------------------------------------
	// Pad drive
	// ------------------------------------------------------------
	// Active-high peripheral enable: 1 means the peripheral drives the pad
	assign periph_oe = periph_i.oe;

	// ------------------------------------------------------------
	// Drive source per pin
	// ------------------------------------------------------------
	// Peripheral first, then the port latch; neither when isolated
	always_comb begin
		drv_on = 8'h00;
		drv_val = 8'h00;
		for (int i = 0; i < 8; i++) begin
			if (periph_oe[i]) begin
				drv_on[i] = 1'b1;
				drv_val[i] = periph_i.dat[i];
			end else if (port_direction_select_q[i]) begin
				drv_on[i] = 1'b1;
				drv_val[i] = port_output_latch_q[i];
			end else begin
				drv_on[i] = 1'b0;
			end
			// Open-drain pins only ever pull low
			if (EGPIO_OPEN_DRAIN_PINS[i] && drv_val[i]) begin
				drv_on[i] = 1'b0;
			end
			if (isolate) begin
				drv_on[i] = 1'b0;
			end
		end
	end

	// Pull-up off while low is driven, saves the static current
	always_comb begin
		pull_on = 8'h00;
		for (int i = 0; i < 8; i++) begin
			pull_on[i] = port_pullup_enable_q[i] && EGPIO_PULL_PINS[i]
				&& !(drv_on[i] && !drv_val[i]);
		end
	end

	always_comb begin
		pad_d.out = drv_val;
		pad_d.oe_b = ~drv_on;
		pad_d.pull_en = pull_on;
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pad_q <= '{out: 8'h00, oe_b: 8'hff, pull_en: 8'h00};
		end else if (clk_en_i) begin
			pad_q <= pad_d;
		end
	end

	// Analog select follows the disable bits inverted
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			analog_sel_q <= 4'hf;
		end else if (clk_en_i) begin
			analog_sel_q <= ~analog_input_disable_low_q;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	// Only the latch read depends on direction and RMW
	assign port_read = egpio_port_read(rmw_read_i, port_output_latch_q,
		port_direction_select_q, periph_oe, pin_level);

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_en) begin
			if (sel_latch) begin
				prdata_q <= {24'h00_0000, port_read};
			end else if (sel_dir) begin
				prdata_q <= {24'h00_0000, port_direction_select_q};
			end else if (sel_pull) begin
				prdata_q <= {24'h00_0000, port_pullup_enable_q};
			end else if (sel_aidl) begin
				prdata_q <= {24'h00_0000, analog_input_disable_low_q[3:2], 2'b00,
					analog_input_disable_low_q[1:0], 2'b00};
			end else if (sel_stby) begin
				prdata_q <= {31'h0000_0000, standby_pin_state_select_q};
			end else begin
				prdata_q <= 32'h0000_0000;
			end
		end
	end

	// Error flag is settled with ready for reads and writes alike
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pslverr_q <= 1'b0;
		end else if (acc_first) begin
			pslverr_q <= sel_none;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pready_q <= 1'b0;
		end else if (clk_en_i) begin
			pready_q <= psel_i && penable_i && !pready_q;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign prdata_o = prdata_q;
	assign pready_o = pready_q;
	assign pslverr_o = pslverr_q;
	assign pad_o = pad_q;
	assign ext_irq_input_six_o = irq6_q;
	assign ext_irq_input_seven_o = irq7_q;
	assign analog_sel_o = analog_sel_q;

endmodule : egpio_port
`default_nettype wire

// ===== verif/egpio_board.sv
// Board model: resolves each pin from port drive, board drive and pull-up
`timescale 1ns/1ps
`default_nettype none
module egpio_board
	import egpio_pkg::*;
(
	input wire logic ref_clk_i,
	input wire egpio_pad_t pad_i,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_val_i,
	output logic [7:0] level_o
);
	// Floating pins toggle so a stale level never passes for a real one
	logic [7:0] last_q = 8'h00;
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pad_i.oe_b[i])
				level_o[i] = pad_i.out[i];
			else if (ext_en_i[i])
				level_o[i] = ext_val_i[i];
			else if (pad_i.pull_en[i])
				level_o[i] = 1'b1;
			else
				level_o[i] = ~last_q[i];
		end
	end
	always_ff @(posedge ref_clk_i) begin
		last_q <= level_o;
	end
endmodule : egpio_board
`default_nettype wire

// ===== verif/egpio_port_assertions.sv
// Checker for the port's bus handshake, pin drive and interrupt feed
`timescale 1ns/1ps
`default_nettype none
module egpio_port_chk
	import egpio_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic clk_en_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic standby_stop_watch_i,
	input wire logic [1:0] ext_irq_enable_i,
	input wire logic [7:0] pad_in_i,
	input wire egpio_pad_t pad_o,
	input wire logic ext_irq_input_six_o,
	input wire logic ext_irq_input_seven_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_b_i);
	ready_one_cycle_a: assert property (pready_o && clk_en_i |=> !pready_o)
		else $error("ready held too long");
	access_answered_a: assert property (psel_i && penable_i && !pready_o && clk_en_i |=> pready_o)
		else $error("access not answered");
	ready_has_cause_a: assert property ($rose(pready_o) |-> $past(psel_i && penable_i))
		else $error("ready without access");
	upper_zero_a: assert property (prdata_o[31:8] == 24'h0)
		else $error("upper read bits set");
	drain_no_high_a: assert property ((~pad_o.oe_b & pad_o.out & EGPIO_OPEN_DRAIN_PINS) == 8'h00)
		else $error("open drain driven high");
	pull_off_low_a: assert property ((pad_o.pull_en & ~pad_o.oe_b & ~pad_o.out) == 8'h00)
		else $error("pull-up on driven-low pin");
	pull_absent_a: assert property ((pad_o.pull_en & ~EGPIO_PULL_PINS) == 8'h00)
		else $error("pull-up on pin without one");
	irq_six_high_a: assert property (((!standby_stop_watch_i || ext_irq_enable_i[0])
		&& pad_in_i[2] && clk_en_i)[*5] |-> ext_irq_input_six_o)
		else $error("irq six feed lost");
	irq_seven_low_a: assert property ((!pad_in_i[3] && clk_en_i)[*5] |-> !ext_irq_input_seven_o)
		else $error("irq seven feed wrong");
	irq_sync_a: assert property ((!pad_in_i[2])[*3] ##1 pad_in_i[2] |=> !ext_irq_input_six_o)
		else $error("pin level not synchronised");
endmodule : egpio_port_chk
bind egpio_port egpio_port_chk u_chk (.ref_clk_i, .rst_b_i, .clk_en_i, .psel_i, .penable_i,
	.prdata_o, .pready_o, .standby_stop_watch_i, .ext_irq_enable_i, .pad_in_i, .pad_o,
	.ext_irq_input_six_o, .ext_irq_input_seven_o);
`default_nettype wire

// ===== verif/tb_top.sv
// Testbench for the eight-bit port
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import egpio_pkg::*;
;
	logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, rmw = 1'b0;
	logic stby = 1'b0, pready, pslverr, six, sev;
	logic cke = 1'b1;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [1:0] irq_en = 2'b00;
	logic [7:0] ext_en = 8'hff, ext_val = 8'hff, lvl;
	logic [3:0] asel;
	egpio_periph_t per = '0;
	egpio_pad_t pad;
	int err_count = 0, n_checks = 0;
	always #50 clk = ~clk;
	egpio_port uut (.ref_clk_i(clk), .rst_b_i(rst_b), .clk_en_i(cke), .psel_i(psel),
		.penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
		.prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .rmw_read_i(rmw),
		.periph_i(per), .standby_stop_watch_i(stby), .ext_irq_enable_i(irq_en),
		.pad_in_i(lvl), .pad_o(pad), .ext_irq_input_six_o(six),
		.ext_irq_input_seven_o(sev), .analog_sel_o(asel));
	egpio_board u_board (.ref_clk_i(clk), .pad_i(pad), .ext_en_i(ext_en),
		.ext_val_i(ext_val), .level_o(lvl));
	// ------------------------------------------------------------
	// Bus and compare tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic r, output logic [31:0] q);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		rmw <= r;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, 1'b0, q);
		repeat (3) @(posedge clk);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic r, input logic [7:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 8'h00, r, q);
		chk(q, {24'h0, e});
	endtask : rd
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rd(EGPIO_OFF_DIR, 1'b0, 8'h00);
		rd(EGPIO_OFF_AIDL, 1'b0, 8'h00);
		chk(pad.oe_b, 8'hff);
		chk(asel, 4'hf);
		rd(EGPIO_OFF_LATCH, 1'b0, 8'hcc);
		$display("reset test done");
	endtask : t_reset
	task automatic t_io();
		wr(EGPIO_OFF_LATCH, 8'ha5);
		chk(pad.oe_b, 8'hff);
		rd(EGPIO_OFF_LATCH, 1'b1, 8'ha5);
		wr(EGPIO_OFF_AIDL, 8'hcc);
		chk(asel, 4'h0);
		rd(EGPIO_OFF_LATCH, 1'b0, 8'hff);
		wr(EGPIO_OFF_DIR, 8'hff);
		chk(pad.oe_b, 8'h80);
		chk(pad.out & 8'h7f, 8'h25);
		ext_val <= 8'h00;
		rd(EGPIO_OFF_LATCH, 1'b0, 8'ha5);
		$display("io test done");
	endtask : t_io
	task automatic t_periph();
		wr(EGPIO_OFF_DIR, 8'h00);
		wr(EGPIO_OFF_LATCH, 8'h00);
		per <= '{oe: 8'h0c, dat: 8'h04};
		repeat (4) @(posedge clk);
		chk(pad.oe_b, 8'hf3);
		chk(pad.out[3:2], 2'b01);
		rd(EGPIO_OFF_LATCH, 1'b0, 8'h04);
		rd(EGPIO_OFF_LATCH, 1'b1, 8'h00);
		per <= '0;
		$display("peripheral test done");
	endtask : t_periph
	task automatic t_pull();
		wr(EGPIO_OFF_PULL, 8'hff);
		wr(EGPIO_OFF_DIR, 8'h01);
		chk(pad.pull_en, 8'h3e);
		$display("pull-up test done");
	endtask : t_pull
	task automatic t_stby();
		wr(EGPIO_OFF_DIR, 8'hff);
		wr(EGPIO_OFF_LATCH, 8'h0f);
		stby <= 1'b1;
		repeat (3) @(posedge clk);
		chk(pad.oe_b, 8'h00);
		stby <= 1'b0;
		wr(EGPIO_OFF_STBY, 8'h01);
		irq_en <= 2'b01;
		ext_val <= 8'h0c;
		stby <= 1'b1;
		repeat (5) @(posedge clk);
		chk(pad.oe_b, 8'hff);
		chk(six, 1'b1);
		chk(sev, 1'b0);
		stby <= 1'b0;
		irq_en <= 2'b00;
		wr(EGPIO_OFF_STBY, 8'h00);
		$display("standby test done");
	endtask : t_stby
	task automatic t_unmapped();
		logic [31:0] q;
		xfer(1'b0, 12'h014, 8'h00, 1'b0, q);
		chk(q, 32'h0);
		chk(pslverr, 1'b1);
		wr(12'h014, 8'h00);
		chk(pslverr, 1'b1);
		rd(EGPIO_OFF_DIR, 1'b0, 8'hff);
		chk(pslverr, 1'b0);
		$display("unmapped test done");
	endtask : t_unmapped
	task automatic t_analog();
		wr(EGPIO_OFF_DIR, 8'h00);
		wr(EGPIO_OFF_PULL, 8'h00);
		wr(EGPIO_OFF_AIDL, 8'h00);
		ext_val <= 8'hff;
		repeat (3) @(posedge clk);
		chk(asel, 4'hf);
		chk(pad.pull_en, 8'h00);
		rd(EGPIO_OFF_LATCH, 1'b0, 8'hcc);
		$display("analog test done");
	endtask : t_analog
	task automatic t_freeze();
		cke <= 1'b0;
		ext_val <= 8'h00;
		repeat (5) @(posedge clk);
		chk(six, 1'b1);
		cke <= 1'b1;
		repeat (5) @(posedge clk);
		chk(six, 1'b0);
		$display("freeze test done");
	endtask : t_freeze
	task automatic summarize();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_io();
		t_periph();
		t_pull();
		t_stby();
		t_unmapped();
		t_analog();
		t_freeze();
		summarize();
	end
	// Whole run is under two hundred cycles; this limit only cuts a hang
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire
